// ==== design/flag_bank_pkg.sv ====
// Package for the monitor alarm, warning and fast-trip flag bank.
// Assumes one system clock; registers are reached by a simple byte port.
package flag_bank_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_PRIMARY_ALARM   = 8'h70;
  localparam logic [7:0] OFS_SECONDARY_ALARM = 8'h71;
  localparam logic [7:0] OFS_TRIP            = 8'h73;
  localparam logic [7:0] OFS_PRIMARY_WARNING = 8'h74;
  localparam logic [7:0] OFS_MASK_FIRST      = 8'hf8;
  localparam logic [7:0] OFS_MASK_LAST       = 8'hfb;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int         BIT_INPUT_THREE_HI  = 7;
  localparam int         BIT_INPUT_THREE_LO  = 6;
  localparam int         BIT_FILTERED_INT    = 0;
  localparam logic [7:0] TRIP_RESET          = 8'h00;
  localparam logic [7:0] TRIP_USED_MASK      = 8'h1f;
  localparam logic [7:0] FLAG_RESET          = 8'h00;

  // Monitored channels
  typedef enum logic [2:0] {
    CH_TEMP,
    CH_SUPPLY,
    CH_INPUT_ONE,
    CH_INPUT_TWO,
    CH_INPUT_THREE
  } channel_e;

  // One completed conversion and its limits
  typedef struct packed {
    logic        valid;
    channel_e    channel;
    logic        is_signed;
    logic [15:0] value;
    logic [15:0] alarm_hi;
    logic [15:0] alarm_lo;
    logic [15:0] warn_hi;
    logic [15:0] warn_lo;
  } conversion_s;

  // Fast-trip comparator results, bit 4 down to bit 0
  typedef struct packed {
    logic bias_warning;
    logic bias_alarm;
    logic signal_absent;
    logic tx_power_low;
    logic tx_power_high;
  } trip_s;

endpackage : flag_bank_pkg

// ==== design/monitor_alarm_warning_flags.sv ====
// Flag bank: threshold alarm and warning flags, fast-trip flags and the
// filtered interrupt. Assumes conversion results arrive as one-cycle
// strobes from a conversion engine on the same clock, and that trip results
// come from comparators on pins, so they are synchronised here.
`timescale 1ns/1ps
`default_nettype none

module monitor_alarm_warning_flags
  import flag_bank_pkg::*;
#(
  parameter int MASK_BYTES = 4
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire conversion_s i_conv,
  input  wire trip_s       i_trip,
  input  wire logic        i_trip_latch_mode,
  input  wire logic        i_mask_set_select,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  output logic             o_reg_hit,
  output logic             o_filtered_interrupt,
  output logic      [4:0]  o_channel_ready
);

  // ---------------------------------------------------------------
  // Comparison helpers
  // ---------------------------------------------------------------
  function automatic logic above(input logic sgn, input logic [15:0] a, input logic [15:0] b);
    above = sgn ? ($signed(a) > $signed(b)) : (a > b);
  endfunction : above

  function automatic logic below(input logic sgn, input logic [15:0] a, input logic [15:0] b);
    below = sgn ? ($signed(a) < $signed(b)) : (a < b);
  endfunction : below

  // ---------------------------------------------------------------
  // Flag storage
  // ---------------------------------------------------------------
  logic [7:0] primary_alarm;
  logic [1:0] input_three_alarm;
  logic [7:0] primary_warning;
  logic [4:0] trip_flags;
  logic [4:0] channel_ready;
  logic [7:0] mask_set_a [MASK_BYTES];
  logic [7:0] mask_set_b [MASK_BYTES];

  wire logic hi_alarm = above(i_conv.is_signed, i_conv.value, i_conv.alarm_hi);
  wire logic lo_alarm = below(i_conv.is_signed, i_conv.value, i_conv.alarm_lo);
  wire logic hi_warn  = above(i_conv.is_signed, i_conv.value, i_conv.warn_hi);
  wire logic lo_warn  = below(i_conv.is_signed, i_conv.value, i_conv.warn_lo);

  // Each channel's pair of flags is rewritten on every conversion, so
  // flags follow the measurement both ways with no host action.
  logic [7:0] next_primary_alarm;
  logic [7:0] next_primary_warning;
  logic [1:0] next_input_three_alarm;
  logic [4:0] next_channel_ready;

  always_comb begin
    next_primary_alarm     = primary_alarm;
    next_primary_warning   = primary_warning;
    next_input_three_alarm = input_three_alarm;
    next_channel_ready     = channel_ready;
    if (i_conv.valid) begin
      next_channel_ready[i_conv.channel] = 1'b1;
      case (i_conv.channel)
        CH_TEMP: begin
          next_primary_alarm[7:6]   = {hi_alarm, lo_alarm};
          next_primary_warning[7:6] = {hi_warn, lo_warn};
        end
        CH_SUPPLY: begin
          next_primary_alarm[5:4]   = {hi_alarm, lo_alarm};
          next_primary_warning[5:4] = {hi_warn, lo_warn};
        end
        CH_INPUT_ONE: begin
          next_primary_alarm[3:2]   = {hi_alarm, lo_alarm};
          next_primary_warning[3:2] = {hi_warn, lo_warn};
        end
        CH_INPUT_TWO: begin
          next_primary_alarm[1:0]   = {hi_alarm, lo_alarm};
          next_primary_warning[1:0] = {hi_warn, lo_warn};
        end
        CH_INPUT_THREE: begin
          next_input_three_alarm    = {hi_alarm, lo_alarm};
        end
        default: begin
          next_channel_ready = channel_ready;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      primary_alarm     <= FLAG_RESET;
      primary_warning   <= FLAG_RESET;
      input_three_alarm <= 2'b00;
      channel_ready     <= 5'h00;
    end else begin
      primary_alarm     <= next_primary_alarm;
      primary_warning   <= next_primary_warning;
      input_three_alarm <= next_input_three_alarm;
      channel_ready     <= next_channel_ready;
    end
  end

  // ---------------------------------------------------------------
  // Fast-trip inputs: three stages, change taken when stages 2 and 3 agree
  // ---------------------------------------------------------------
  logic [4:0] trip_s1;
  logic [4:0] trip_s2;
  logic [4:0] trip_s3;
  logic [4:0] trip_clean;

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      trip_s1 <= 5'h00;
      trip_s2 <= 5'h00;
      trip_s3 <= 5'h00;
    end else begin
      trip_s1 <= i_trip;
      trip_s2 <= trip_s1;
      trip_s3 <= trip_s2;
    end
  end

  wire logic [4:0] trip_agree = ~(trip_s2 ^ trip_s3);
  wire logic [4:0] next_trip_clean = (trip_agree & trip_s3) | (~trip_agree & trip_clean);

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      trip_clean <= 5'h00;
    end else begin
      trip_clean <= next_trip_clean;
    end
  end

  // ---------------------------------------------------------------
  // Register access decode
  // ---------------------------------------------------------------
  wire logic wr_trip   = i_reg_wr && (i_reg_addr == OFS_TRIP);
  wire logic in_masks  = (i_reg_addr >= OFS_MASK_FIRST) && (i_reg_addr <= OFS_MASK_LAST);
  wire logic [1:0] mask_index = i_reg_addr[1:0];

  // In latched mode a comparator event sets a flag; a host write of 0 clears
  // it unless the event is present in the same cycle, where the set wins.
  wire logic [4:0] trip_write_keep = wr_trip ? i_reg_wdata[4:0] : 5'h1f;
  wire logic [4:0] next_trip_flags = i_trip_latch_mode ?
                                     ((trip_flags & trip_write_keep) | trip_clean) :
                                     trip_clean;

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      trip_flags <= TRIP_RESET[4:0];
    end else begin
      trip_flags <= next_trip_flags;
    end
  end

  // Mask bytes; two sets share the same offsets, the select bit steers writes
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      for (int k = 0; k < MASK_BYTES; k++) begin
        mask_set_a[k] <= 8'h00;
        mask_set_b[k] <= 8'h00;
      end
    end else if (i_reg_wr && in_masks) begin
      if (i_mask_set_select) begin
        mask_set_b[mask_index] <= i_reg_wdata;
      end else begin
        mask_set_a[mask_index] <= i_reg_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Filtered interrupt
  // ---------------------------------------------------------------
  // Mask layout: byte 0 primary alarms, byte 1 input-three alarms,
  // byte 2 primary warnings, byte 3 unused here.
  wire logic [7:0] mask_sel [MASK_BYTES];
  for (genvar g = 0; g < MASK_BYTES; g++) begin : g_mask_sel
    assign mask_sel[g] = i_mask_set_select ? mask_set_b[g] : mask_set_a[g];
  end

  wire logic [7:0] alarm_two_flags = {input_three_alarm, 6'h00};
  wire logic interrupt_term = |(primary_alarm & mask_sel[0])
                            | |(alarm_two_flags & mask_sel[1])
                            | |(primary_warning & mask_sel[2]);

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_filtered_interrupt <= 1'b0;
    end else begin
      o_filtered_interrupt <= interrupt_term;
    end
  end

  // ---------------------------------------------------------------
  // Named flags
  // ---------------------------------------------------------------
  wire logic temp_high_alarm_flag        = primary_alarm[7];
  wire logic temp_low_alarm_flag         = primary_alarm[6];
  wire logic supply_high_alarm_flag      = primary_alarm[5];
  wire logic supply_low_alarm_flag       = primary_alarm[4];
  wire logic input_one_high_alarm_flag   = primary_alarm[3];
  wire logic input_one_low_alarm_flag    = primary_alarm[2];
  wire logic input_two_high_alarm_flag   = primary_alarm[1];
  wire logic input_two_low_alarm_flag    = primary_alarm[0];
  wire logic input_three_high_alarm_flag = input_three_alarm[1];
  wire logic input_three_low_alarm_flag  = input_three_alarm[0];
  wire logic filtered_interrupt_flag     = o_filtered_interrupt;

  wire logic temp_high_warning_flag      = primary_warning[7];
  wire logic temp_low_warning_flag       = primary_warning[6];
  wire logic supply_high_warning_flag    = primary_warning[5];
  wire logic supply_low_warning_flag     = primary_warning[4];
  wire logic input_one_high_warning_flag = primary_warning[3];
  wire logic input_one_low_warning_flag  = primary_warning[2];
  wire logic input_two_high_warning_flag = primary_warning[1];
  wire logic input_two_low_warning_flag  = primary_warning[0];

  wire logic bias_warning_trip_flag      = trip_flags[4];
  wire logic bias_alarm_trip_flag        = trip_flags[3];
  wire logic signal_absent_trip_flag     = trip_flags[2];
  wire logic tx_power_low_trip_flag      = trip_flags[1];
  wire logic tx_power_high_trip_flag     = trip_flags[0];

  // ---------------------------------------------------------------
  // Read bytes, assembled bit by bit
  // ---------------------------------------------------------------
  wire logic [7:0] alarm_byte_one = {
    temp_high_alarm_flag,
    temp_low_alarm_flag,
    supply_high_alarm_flag,
    supply_low_alarm_flag,
    input_one_high_alarm_flag,
    input_one_low_alarm_flag,
    input_two_high_alarm_flag,
    input_two_low_alarm_flag
  };

  wire logic [7:0] warning_byte = {
    temp_high_warning_flag,
    temp_low_warning_flag,
    supply_high_warning_flag,
    supply_low_warning_flag,
    input_one_high_warning_flag,
    input_one_low_warning_flag,
    input_two_high_warning_flag,
    input_two_low_warning_flag
  };

  wire logic [7:0] trip_byte_named = {
    3'b000,
    bias_warning_trip_flag,
    bias_alarm_trip_flag,
    signal_absent_trip_flag,
    tx_power_low_trip_flag,
    tx_power_high_trip_flag
  };

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  wire logic [7:0] secondary_byte = {
    input_three_high_alarm_flag,
    input_three_low_alarm_flag,
    5'h00,
    filtered_interrupt_flag
  };
  wire logic [7:0] trip_byte      = trip_byte_named & TRIP_USED_MASK;
  wire logic       known_addr     = (i_reg_addr == OFS_PRIMARY_ALARM) ||
                                    (i_reg_addr == OFS_SECONDARY_ALARM) ||
                                    (i_reg_addr == OFS_TRIP) ||
                                    (i_reg_addr == OFS_PRIMARY_WARNING) || in_masks;
  logic [7:0] next_rdata;

  always_comb begin
    case (i_reg_addr)
      OFS_PRIMARY_ALARM:   next_rdata = alarm_byte_one;
      OFS_SECONDARY_ALARM: next_rdata = secondary_byte;
      OFS_TRIP:            next_rdata = trip_byte;
      OFS_PRIMARY_WARNING: next_rdata = warning_byte;
      default:             next_rdata = in_masks ? mask_sel[mask_index] : 8'h00;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_reg_rdata <= 8'h00;
      o_reg_hit   <= 1'b0;
    end else begin
      o_reg_rdata <= i_reg_rd ? next_rdata : o_reg_rdata;
      o_reg_hit   <= i_reg_rd && known_addr;
    end
  end

  assign o_channel_ready = channel_ready;

endmodule : monitor_alarm_warning_flags

`default_nettype wire

// ==== testbench/conv_engine.sv ====
// Stand-in for the conversion engine: one-cycle result strobe with fixed limits.
// Assumes the bench raises i_go for exactly one clock cycle.
`timescale 1ns/1ps
`default_nettype none
module conv_engine
  import flag_bank_pkg::*;
#(
  parameter logic [15:0] AH = 16'h6000,
  parameter logic [15:0] AL = 16'h1000,
  parameter logic [15:0] WH = 16'h5000,
  parameter logic [15:0] WL = 16'h2000
) (
  input  wire logic        i_go,
  input  wire channel_e    i_ch,
  input  wire logic [15:0] i_val,
  output var  conversion_s o_conv
);
  // Between strobes the value shows its inverse, never a stale copy
  assign o_conv = '{i_go, i_ch, i_ch == CH_TEMP, i_go ? i_val : ~i_val, AH, AL, WH, WL};
endmodule : conv_engine
`default_nettype wire

// ==== testbench/flag_bank_checker.sv ====
// Checker for the flag bank, watching only the top module's ports.
// Assumes one clock and the active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module flag_bank_checker
  import flag_bank_pkg::*;
#(
  parameter int MASK_BYTES = 4
) (
  input wire logic i_clk_sys, input wire logic i_reset, input wire conversion_s i_conv,
  input wire trip_s i_trip, input wire logic i_trip_latch_mode, input wire logic i_mask_set_select,
  input wire logic i_reg_wr, input wire logic i_reg_rd, input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata, input wire logic [7:0] o_reg_rdata, input wire logic o_reg_hit,
  input wire logic o_filtered_interrupt, input wire logic [4:0] o_channel_ready
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  wire rd_trip = i_reg_rd && i_reg_addr == OFS_TRIP;
  property p_unmapped; i_reg_rd && i_reg_addr == 8'h72 |=> !o_reg_hit && o_reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
  property p_trip_top; rd_trip |=> o_reg_hit && o_reg_rdata[7:5] == 3'h0; endproperty
  a_trip_top: assert property (p_trip_top) else $error("trip upper bits set");
  property p_second;
    i_reg_rd && i_reg_addr == OFS_SECONDARY_ALARM |=> o_reg_rdata[5:1] == 5'h0 && o_reg_rdata[0] == $past(o_filtered_interrupt);
  endproperty
  a_second: assert property (p_second) else $error("second alarm byte wrong");
  property p_ready_keep; ($past(o_channel_ready) & ~o_channel_ready) == 5'h0; endproperty
  a_ready_keep: assert property (p_ready_keep) else $error("ready bit fell");
  property p_ready_set; i_conv.valid |=> o_channel_ready[$past(i_conv.channel)]; endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready not set");
  property p_trip_follow;
    (!i_trip_latch_mode && $stable(i_trip))[*5] ##0 rd_trip |=> o_reg_rdata[4:0] == $past(i_trip);
  endproperty
  a_trip_follow: assert property (p_trip_follow) else $error("trip flags stale");
  property p_supply_alarm;
    i_conv.valid && i_conv.channel == CH_SUPPLY ##1 i_reg_rd && i_reg_addr == OFS_PRIMARY_ALARM |=>
      o_reg_rdata[5:4] == {$past(i_conv.value, 2) > $past(i_conv.alarm_hi, 2),
                           $past(i_conv.value, 2) < $past(i_conv.alarm_lo, 2)};
  endproperty
  a_supply_alarm: assert property (p_supply_alarm) else $error("supply alarm wrong");
  property p_one_warn;
    i_conv.valid && i_conv.channel == CH_INPUT_ONE ##2 i_reg_rd && i_reg_addr == OFS_PRIMARY_WARNING |=>
      o_reg_rdata[3:2] == {$past(i_conv.value, 3) > $past(i_conv.warn_hi, 3),
                           $past(i_conv.value, 3) < $past(i_conv.warn_lo, 3)};
  endproperty
  a_one_warn: assert property (p_one_warn) else $error("input one warning wrong");
  c_temp: cover property (i_conv.valid && i_conv.channel == CH_TEMP);
  c_irq: cover property ($rose(o_filtered_interrupt));
  c_clear: cover property (i_trip_latch_mode && i_reg_wr && i_reg_addr == OFS_TRIP);
endmodule : flag_bank_checker
bind monitor_alarm_warning_flags flag_bank_checker #(.MASK_BYTES(MASK_BYTES)) u_checker (.i_clk_sys(i_clk_sys),
  .i_reset(i_reset), .i_conv(i_conv), .i_trip(i_trip), .i_trip_latch_mode(i_trip_latch_mode),
  .i_mask_set_select(i_mask_set_select), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_hit(o_reg_hit),
  .o_filtered_interrupt(o_filtered_interrupt), .o_channel_ready(o_channel_ready));
`default_nettype wire

// ==== testbench/test_monitor_alarm_warning_flags.sv ====
// Bench for the flag bank: corner and random conversions, masks, trip flags.
// Assumes the package, the conversion engine model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_monitor_alarm_warning_flags;
  import flag_bank_pkg::*;
  localparam logic [15:0] AH = 16'h6000, AL = 16'h1000, WH = 16'h5000, WL = 16'h2000;
  logic        clk = 0, rst = 1, go = 0, latch = 0, msel = 0, wr = 0, rd = 0, hit, irq;
  logic [7:0]  addr = 0, wdata = 0, rdata, d;
  logic [15:0] val = 0;
  logic [31:0] rnd = 32'h0a24;
  logic [4:0]  ready;
  logic [4:0]  pat [3] = '{5'h15, 5'h0a, 5'h00};
  logic [15:0] corner [8] = '{AH, AH + 16'h1, AL, AL - 16'h1, WH + 16'h1, 16'hff00, WL - 16'h1, WL};
  channel_e    ch = CH_TEMP;
  trip_s       trip = '0;
  conversion_s conv;
  int          failures = 0, n_checks = 0, cycles = 0;

  conv_engine #(.AH(AH), .AL(AL), .WH(WH), .WL(WL)) i_eng (.i_go(go), .i_ch(ch), .i_val(val), .o_conv(conv));
  monitor_alarm_warning_flags i_dut (.i_clk_sys(clk), .i_reset(rst), .i_conv(conv), .i_trip(trip),
    .i_trip_latch_mode(latch), .i_mask_set_select(msel), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_hit(hit), .o_filtered_interrupt(irq), .o_channel_ready(ready));

  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      close_out();
    end
  end

  function automatic logic [31:0] next_rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rnd
  function automatic logic [3:0] exp_flags(input channel_e c, input logic [15:0] v);
    if (c == CH_TEMP)
      return {$signed(v) > $signed(AH), $signed(v) < $signed(AL), $signed(v) > $signed(WH), $signed(v) < $signed(WL)};
    return {v > AH, v < AL, v > WH, v < WL};
  endfunction : exp_flags
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic reg_rd(input logic [7:0] a);
    rd = 1;
    addr = a;
    tick(1);
    rd = 0;
    d = rdata | {7'h0, !hit && a == 8'h72};
  endtask : reg_rd
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    wr = 1;
    addr = a;
    wdata = v;
    tick(1);
    wr = 0;
  endtask : reg_wr
  task automatic conv_chk(input channel_e c, input logic [15:0] v);
    logic [3:0] e;
    logic [1:0] g;
    e = exp_flags(c, v);
    go = 1;
    ch = c;
    val = v;
    tick(1);
    go = 0;
    reg_rd(c == CH_INPUT_THREE ? OFS_SECONDARY_ALARM : OFS_PRIMARY_ALARM);
    g = c == CH_INPUT_THREE ? d[7:6] : d[7 - 2 * int'(c) -: 2];
    chk("alarm", {6'h0, e[3:2]}, {6'h0, g});
    if (c != CH_INPUT_THREE) begin
      reg_rd(OFS_PRIMARY_WARNING);
      chk("warning", {6'h0, e[1:0]}, {6'h0, d[7 - 2 * int'(c) -: 2]});
    end
  endtask : conv_chk
  task automatic irq_chk(input logic exp);
    tick(3);
    chk("interrupt", {7'h0, exp}, {7'h0, irq});
  endtask : irq_chk
  task automatic close_out;
    $display("Checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  initial begin
    tick(8);
    rst = 0;
    reg_rd(OFS_TRIP);
    chk("trip", 8'h00, d);
    chk("ready", 8'h00, {3'h0, ready});
    reg_rd(8'h72);
    chk("unmapped", 8'h01, d);
    foreach (corner[i]) conv_chk(channel_e'(3'(i % 5)), corner[i]);
    repeat (30) begin
      rnd = next_rnd(rnd);
      conv_chk(channel_e'(3'(rnd[2:0] % 3'd5)), rnd[31:16]);
    end
    chk("ready", 8'h1f, {3'h0, ready});
    conv_chk(CH_TEMP, 16'h7000);
    reg_wr(OFS_MASK_FIRST, 8'h80);
    irq_chk(1'b1);
    reg_rd(OFS_SECONDARY_ALARM);
    chk("interrupt bit", 8'h01, {7'h0, d[0]});
    reg_wr(OFS_MASK_FIRST, 8'h00);
    irq_chk(1'b0);
    reg_wr(OFS_MASK_FIRST + 8'h2, 8'h80);
    irq_chk(1'b1);
    msel = 1;
    irq_chk(1'b0);
    msel = 0;
    irq_chk(1'b1);
    reg_wr(OFS_SECONDARY_ALARM, 8'hff);
    reg_rd(OFS_SECONDARY_ALARM);
    chk("reserved", 8'h00, {2'h0, d[5:1], 1'b0});
    foreach (pat[i]) begin
      trip = trip_s'(pat[i]);
      tick(5);
      reg_rd(OFS_TRIP);
      chk("trip", {3'h0, pat[i]}, d);
    end
    latch = 1;
    trip = '1;
    tick(5);
    trip = '0;
    tick(5);
    reg_rd(OFS_TRIP);
    chk("trip held", 8'h1f, d);
    reg_wr(OFS_TRIP, 8'h00);
    tick(1);
    reg_rd(OFS_TRIP);
    chk("trip cleared", 8'h00, d);
    close_out();
  end
endmodule : test_monitor_alarm_warning_flags
`default_nettype wire
